// *** rtl/dma_bus_mode_channel_arbiter.sv ***
// Purpose: bus-mode control and channel arbitration for four dma channels
// Assumes: all inputs synchronous to clock; unit_done ends each unit
// Notes: configuration arrives on plain ports, no software registers
`timescale 1ns/100ps
`default_nettype none

module dma_bus_mode_channel_arbiter
    import dma_arb_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // per-channel configuration
    input wire logic [NUM_CH-1:0] ch_enable,
    input wire logic [NUM_CH-1:0] bus_mode_select,
    input wire logic [3*NUM_CH-1:0] ch_source,
    input wire logic [2*NUM_CH-1:0] ch_category,
    input wire logic [2*NUM_CH-1:0] ch_size,
    input wire logic [NUM_CH-1:0] ch_end,
    input wire logic round_robin,
    // request inputs
    input wire logic [EXT_CH-1:0] dma_request_pin_n,
    input wire logic [NUM_CH-1:0] internal_req,
    // system bus arbitration
    output logic bus_request,
    input wire logic bus_grant,
    // unit transfer control
    output logic unit_start_ff,
    output logic [1:0] unit_channel_ff,
    output logic [1:0] unit_size_ff,
    output logic [EXT_CH-1:0] dma_acknowledge_strobe_ff,
    input wire logic unit_done,
    output logic [NUM_CH-1:0] cfg_error_ff,
    // data buffer, read side in
    input wire logic src_valid,
    input wire logic [DATA_W-1:0] src_data,
    output logic src_ready,
    // data buffer, write side out
    output logic dst_valid,
    output logic [DATA_W-1:0] dst_data,
    input wire logic dst_ready
);

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic rst_meta_ff;
    logic rst_n_ff;

    // two stages so the release never lands mid-setup
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff <= rst_meta_ff;
        end
    end

    // every check runs on the system clock and sleeps while in reset
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n_ff);

    // ----------------------------------------------------------------
    // per-channel legality and request qualification
    // ----------------------------------------------------------------
    logic [NUM_CH-1:0] cfg_ok;
    logic [NUM_CH-1:0] eff_burst;
    logic [NUM_CH-1:0] req_ok;
    logic [NUM_CH-1:0] is_ack;

    genvar c;
    generate
        for (c = 0; c < NUM_CH; c++) begin : g_ch
            wire logic [2:0] src = ch_source[3*c +: 3];
            wire logic [1:0] cat = ch_category[2*c +: 2];
            wire logic [1:0] sz = ch_size[2*c +: 2];
            wire logic ext = (src == SRC_EXT);
            wire logic serial_src = (src == SRC_SERIAL) ||
                (src == SRC_FIFO_SERIAL) || (src == SRC_ADC);
            wire logic pin_low;
            wire logic src_active;
            // external pin only exists on the low channels
            if (c < EXT_CH) begin : g_pin
                assign pin_low = !dma_request_pin_n[c];
            end else begin : g_nopin
                assign pin_low = 1'b0;
            end
            // an external source elsewhere is refused outright
            wire logic ext_ok = !ext || (c < EXT_CH);
            // acknowledged device needs the pin and a low channel
            wire logic ack_ok = (cat != CAT_ACK) ||
                (ext && (c < EXT_CH));
            // peripheral registers stop at 32 bits
            wire logic size_ok = (cat != CAT_PERI) || (sz != SZ_128);
            // memory categories take external, auto or timer
            wire logic mem_ok = (cat != CAT_MEM) || ext ||
                (src == SRC_AUTO) || (src == SRC_TIMER);
            assign cfg_ok[c] = ext_ok && ack_ok && size_ok && mem_ok;
            // serial and converter sources always cycle-steal
            assign eff_burst[c] = bus_mode_select[c] && !serial_src;
            assign is_ack[c] = (cat == CAT_ACK);
            // pin high drops the request, the running unit finishes
            assign src_active = ext ? pin_low :
                (src == SRC_AUTO) ? 1'b1 : internal_req[c];
            assign req_ok[c] = ch_enable[c] && !ch_end[c] &&
                cfg_ok[c] && src_active;

            a_serial_steal: assert property (
                (serial_src && ch_enable[c]) |-> !eff_burst[c])
                else $error("serial source ran in burst");
        end
    endgenerate

    // ----------------------------------------------------------------
    // channel selection
    // ----------------------------------------------------------------
    // first requesting channel starting from the given channel
    function automatic logic [2:0] pick(input logic [NUM_CH-1:0] req,
                                        input logic [1:0] first);
        logic found;
        logic [1:0] idx;
        logic [1:0] j;
        found = 1'b0;
        idx = first;
        for (int k = 0; k < NUM_CH; k++) begin
            j = first + k[1:0];
            if (!found && req[j]) begin
                found = 1'b1;
                idx = j;
            end
        end
        return {found, idx};
    endfunction

    arb_state_e state_ff;
    arb_state_e nxt_state;
    logic [1:0] rr_ff;
    wire logic [1:0] first_ch = round_robin ? rr_ff : 2'h0;
    wire logic [2:0] pick_res = pick(req_ok, first_ch);
    wire logic win_valid = pick_res[2];
    wire logic [1:0] win_ch = pick_res[1:0];
    wire logic any_burst = |(req_ok & eff_burst);
    wire logic keep_bus = win_valid && any_burst;
    logic buf_full;
    // no new unit while the buffer has no room, so no word is lost
    wire logic can_start = (state_ff == ST_REQ) && bus_grant &&
        win_valid && !buf_full;
    wire logic unit_end = (state_ff == ST_XFER) && unit_done;

    // ----------------------------------------------------------------
    // bus ownership state machine
    // ----------------------------------------------------------------
    // bus stays held between units only while a burst channel waits
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (win_valid) begin
                    nxt_state = ST_REQ;
                end
            end
            ST_REQ: begin
                if (can_start) begin
                    nxt_state = ST_XFER;
                end else if (!win_valid) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_XFER: begin
                if (unit_done) begin
                    // cycle-steal hands the bus back after each unit unless a burst channel waits
                    nxt_state = keep_bus ? ST_REQ : ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // request stays up until release, the arbiter holds grant
    assign bus_request = (state_ff != ST_IDLE);

    // ----------------------------------------------------------------
    // unit issue and round-robin pointer
    // ----------------------------------------------------------------
    // served channel drops to lowest, so two channels alternate
    wire logic [1:0] nxt_rr = (can_start && round_robin) ?
        win_ch + 2'h1 : rr_ff;

    always_ff @(posedge clock or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            rr_ff <= 2'h0;
            unit_start_ff <= 1'b0;
            unit_channel_ff <= 2'h0;
            unit_size_ff <= SZ_8;
        end else begin
            rr_ff <= nxt_rr;
            unit_start_ff <= can_start;
            if (can_start) begin
                unit_channel_ff <= win_ch;
                unit_size_ff <= ch_size[2*win_ch +: 2];
            end
        end
    end

    // ----------------------------------------------------------------
    // acknowledge strobe and configuration errors
    // ----------------------------------------------------------------
    logic [EXT_CH-1:0] nxt_ack;
    genvar a;
    generate
        for (a = 0; a < EXT_CH; a++) begin : g_ack
            // strobe spans the whole unit of an acknowledged channel
            assign nxt_ack[a] =
                (can_start && win_ch == a && is_ack[a]) ? 1'b1 :
                unit_end ? 1'b0 : dma_acknowledge_strobe_ff[a];
        end
    endgenerate

    always_ff @(posedge clock or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            dma_acknowledge_strobe_ff <= '0;
            cfg_error_ff <= '0;
        end else begin
            dma_acknowledge_strobe_ff <= nxt_ack;
            cfg_error_ff <= ch_enable & ~cfg_ok;
        end
    end

    // ----------------------------------------------------------------
    // two-entry data buffer
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] buf_mem [BUF_DEPTH];
    logic wr_ptr_ff;
    logic rd_ptr_ff;
    logic [1:0] count_ff;
    wire logic push = src_valid && src_ready;
    wire logic pop = dst_valid && dst_ready;
    wire logic [1:0] nxt_count = count_ff + {1'b0, push} - {1'b0, pop};

    assign buf_full = (count_ff == 2'(BUF_DEPTH));
    assign src_ready = !buf_full;
    assign dst_valid = (count_ff != 2'h0);
    assign dst_data = buf_mem[rd_ptr_ff];

    // storage has no reset; only the pointers and count need one
    always_ff @(posedge clock) begin
        if (push) begin
            buf_mem[wr_ptr_ff] <= src_data;
        end
    end

    always_ff @(posedge clock or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            count_ff <= 2'h0;
        end else begin
            wr_ptr_ff <= wr_ptr_ff ^ push;
            rd_ptr_ff <= rd_ptr_ff ^ pop;
            count_ff <= nxt_count;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_grant_start: assert property (
        unit_start_ff |-> $past(bus_grant) && bus_request)
        else $error("unit started without bus grant");

    a_steal_release: assert property (
        (unit_end && !keep_bus) |=> !bus_request && !unit_start_ff)
        else $error("bus kept after cycle-steal unit");

    a_burst_hold: assert property (
        (unit_end && keep_bus) |=> bus_request [*2])
        else $error("bus dropped during burst");

    a_reclaim_bus: assert property (
        (state_ff == ST_IDLE && win_valid) |=> bus_request)
        else $error("pending request did not reclaim bus");

    a_ack_channel: assert property (
        unit_start_ff && (|dma_acknowledge_strobe_ff) |->
        unit_channel_ff < 2'(EXT_CH))
        else $error("acknowledge strobe on high channel");

    a_ext_channel: assert property (
        can_start |-> ch_source[3*win_ch +: 3] != SRC_EXT ||
        win_ch < 2'(EXT_CH))
        else $error("external request on high channel");

    a_peri_size: assert property (
        can_start && ch_category[2*win_ch +: 2] == CAT_PERI |=>
        unit_size_ff != SZ_128)
        else $error("128-bit unit on peripheral");

    a_fixed_order: assert property (
        (can_start && !round_robin && win_ch != 2'h0) |-> !req_ok[0])
        else $error("lower channel served over channel 0");

    a_rr_rotate: assert property (
        (can_start && round_robin) |=> rr_ff == unit_channel_ff + 2'h1)
        else $error("served channel not moved to lowest");

    a_buf_stall: assert property (
        buf_full |-> !src_ready && !can_start)
        else $error("buffer accepted while full");

    a_start_single: assert property (
        unit_start_ff |=> !unit_start_ff)
        else $error("two units started back to back");

    a_ack_span: assert property (
        (|dma_acknowledge_strobe_ff) |-> bus_request)
        else $error("acknowledge strobe without bus");

    a_pin_release: assert property (
        (unit_end && !win_valid) |=> !bus_request)
        else $error("bus kept with no request left");

    a_ended_idle: assert property (
        can_start |-> !ch_end[win_ch])
        else $error("unit started on an ended channel");

    a_fixed_lowest: assert property (
        (can_start && !round_robin) |->
        (req_ok & ((4'h1 << win_ch) - 4'h1)) == 4'h0)
        else $error("lower channel number left waiting");

endmodule // dma_bus_mode_channel_arbiter

`default_nettype wire

// *** rtl/dma_arb_pkg.sv ***
// Purpose: constants and types shared by the bus-mode channel arbiter
// Assumes: four channels, 32-bit data word, one system bus arbiter
`default_nettype none

package dma_arb_pkg;

    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int NUM_CH = 4;
    localparam int DATA_W = 32;
    localparam int BUF_DEPTH = 2;
    localparam int EXT_CH = 2; // channels below this own a request pin

    // ----------------------------------------------------------------
    // request sources, transfer categories, unit sizes
    // ----------------------------------------------------------------
    localparam logic [2:0] SRC_EXT = 3'h0;
    localparam logic [2:0] SRC_AUTO = 3'h1;
    localparam logic [2:0] SRC_TIMER = 3'h2;
    localparam logic [2:0] SRC_SERIAL = 3'h3; // plain serial or infrared
    localparam logic [2:0] SRC_FIFO_SERIAL = 3'h4;
    localparam logic [2:0] SRC_ADC = 3'h5;

    localparam logic [1:0] CAT_MEM = 2'h0;  // external, mapped or x/y
    localparam logic [1:0] CAT_PERI = 2'h1; // on-chip peripheral involved
    localparam logic [1:0] CAT_ACK = 2'h2;  // acknowledge-strobed device

    localparam logic [1:0] SZ_8 = 2'h0;
    localparam logic [1:0] SZ_16 = 2'h1;
    localparam logic [1:0] SZ_32 = 2'h2;
    localparam logic [1:0] SZ_128 = 2'h3;

    // ----------------------------------------------------------------
    // arbiter states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_REQ,
        ST_XFER
    } arb_state_e;

endpackage

`default_nettype wire

// *** sim/bus_partner.sv ***
// Purpose: system bus arbiter and memory facing the dma arbiter
// Assumes: grant is held for as long as bus_request stays high
// Notes: slow stretches both the grant wait and the unit length
`timescale 1ns/100ps
`default_nettype none

module bus_partner (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // pacing
    input wire logic slow,
    // bus arbitration
    input wire logic bus_request,
    output logic bus_grant,
    // unit timing
    input wire logic unit_start_ff,
    output logic unit_done
);
    int wait_cnt;
    int busy_cnt;

    // grant only after a wait, never withdrawn while still requested
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bus_grant <= 1'b0;
            wait_cnt <= 0;
        end else if (bus_request !== 1'b1) begin
            bus_grant <= 1'b0;
            wait_cnt <= 0;
        end else if (wait_cnt >= (slow ? 3 : 0)) begin
            bus_grant <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 1;
        end
    end

    // memory ends each unit after one or four cycles, one-cycle pulse
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            busy_cnt <= 0;
            unit_done <= 1'b0;
        end else begin
            unit_done <= (busy_cnt == 1);
            if (unit_start_ff === 1'b1) begin
                busy_cnt <= slow ? 4 : 1;
            end else if (busy_cnt > 0) begin
                busy_cnt <= busy_cnt - 1;
            end
        end
    end
endmodule // bus_partner

`default_nettype wire

// *** sim/dma_bus_mode_channel_arbiter_bench.sv ***
// Purpose: self-checking bench for the dma bus-mode channel arbiter
// Assumes: bus_partner grants the bus and times every unit
// Notes: inputs change on the falling edge; expectations from queues
`timescale 1ns/100ps
`default_nettype none

module dma_bus_mode_channel_arbiter_bench
    import dma_arb_pkg::*;
;

    logic clock, resetn, round_robin, bus_request, bus_grant, slow;
    logic [3:0] ch_enable, bus_mode_select, ch_end, internal_req;
    logic [11:0] ch_source;
    logic [7:0] ch_category, ch_size;
    logic [1:0] dma_request_pin_n, unit_channel_ff, unit_size_ff;
    logic [1:0] dma_acknowledge_strobe_ff;
    logic unit_start_ff, unit_done, src_valid, src_ready;
    logic dst_valid, dst_ready, ack_seen, req_d;
    logic [3:0] cfg_error_ff;
    logic [31:0] src_data, dst_data;
    int bad_count, checked, rel, cycles;
    int seed = 32'h794b;
    logic [3:0] seen[$];
    logic [31:0] q[$];

    dma_bus_mode_channel_arbiter uut (.clock(clock), .resetn(resetn),
        .ch_enable(ch_enable), .bus_mode_select(bus_mode_select),
        .ch_source(ch_source), .ch_category(ch_category),
        .ch_size(ch_size), .ch_end(ch_end), .round_robin(round_robin),
        .dma_request_pin_n(dma_request_pin_n),
        .internal_req(internal_req), .bus_request(bus_request),
        .bus_grant(bus_grant), .unit_start_ff(unit_start_ff),
        .unit_channel_ff(unit_channel_ff), .unit_size_ff(unit_size_ff),
        .dma_acknowledge_strobe_ff(dma_acknowledge_strobe_ff),
        .unit_done(unit_done), .cfg_error_ff(cfg_error_ff),
        .src_valid(src_valid), .src_data(src_data),
        .src_ready(src_ready), .dst_valid(dst_valid),
        .dst_data(dst_data), .dst_ready(dst_ready));

    bus_partner far_side (.clock(clock), .resetn(resetn), .slow(slow),
        .bus_request(bus_request), .bus_grant(bus_grant),
        .unit_start_ff(unit_start_ff), .unit_done(unit_done));

    // ----------------------------------------------------------------
    // clock, monitor and shared tasks
    // ----------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // records units and bus releases; the cycle ceiling cuts a hang
    always @(posedge clock) begin
        if (unit_start_ff === 1'b1) begin
            seen.push_back({unit_size_ff, unit_channel_ff});
        end
        if (dma_acknowledge_strobe_ff !== 2'h0) begin
            ack_seen = 1'b1;
        end
        if (req_d === 1'b1 && bus_request === 1'b0) begin
            rel++;
        end
        req_d = bus_request;
        cycles++;
        if (cycles > 20000) begin
            bad_count++;
            end_sim();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic cfg(input int c, input logic [2:0] src,
            input logic [1:0] cat, input logic [1:0] sz, input logic bm);
        ch_source[3*c +: 3] = src;
        ch_category[2*c +: 2] = cat;
        ch_size[2*c +: 2] = sz;
        bus_mode_select[c] = bm;
    endtask

    // one channel alone: legal ones run until ended, bad ones never run
    task automatic run_case(input int c, input logic [2:0] src,
            input logic [1:0] cat, input logic [1:0] sz, input logic bm,
            input logic err);
        logic forced;
        forced = src inside {SRC_SERIAL, SRC_FIFO_SERIAL, SRC_ADC};
        @(negedge clock);
        slow = 1'($random(seed));
        seen.delete();
        rel = 0;
        ack_seen = 1'b0;
        cfg(c, src, cat, sz, bm);
        ch_enable[c] = 1'b1;
        if (err) begin
            idle(30);
            check(cfg_error_ff[c], 1);
            check(seen.size(), 0);
        end else begin
            while (seen.size() < 3) @(negedge clock);
            ch_end[c] = 1'b1;
            idle(30);
            foreach (seen[i]) check(seen[i], {sz, 2'(c)});
            check(rel, (bm && !forced) ? 1 : seen.size());
            check(cfg_error_ff[c], 0);
        end
        check(ack_seen, cat == CAT_ACK && !err);
        ch_enable[c] = 1'b0;
        ch_end[c] = 1'b0;
    endtask

    // ch1 bursts, ch0 then joins; fixed keeps ch0, round-robin swaps
    task automatic prio(input logic rr);
        @(negedge clock);
        round_robin = rr;
        cfg(1, SRC_AUTO, CAT_MEM, SZ_32, 1'b1);
        cfg(0, SRC_AUTO, CAT_MEM, SZ_16, 1'b0);
        ch_enable[1] = 1'b1;
        idle(20);
        ch_enable[0] = 1'b1;
        idle(12);
        seen.delete();
        rel = 0;
        while (seen.size() < 6) @(negedge clock);
        for (int i = 1; i < 6; i++) begin
            check(seen[i][1:0],
                rr ? 2'h1 - seen[i-1][1:0] : 2'h0);
        end
        check(rel, 0);
        ch_end[0] = 1'b1;
        seen.delete();
        while (seen.size() < 3) @(negedge clock);
        check(seen[2][1:0], 1);
        ch_end = 4'hF;
        idle(30);
        ch_enable = 4'h0;
        ch_end = 4'h0;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        int units;
        resetn = 1'b0;
        slow = 1'b0;
        round_robin = 1'b0;
        ch_enable = 4'h0;
        bus_mode_select = 4'h0;
        ch_end = 4'h0;
        internal_req = 4'hF;
        ch_source = 12'h000;
        ch_category = 8'h00;
        ch_size = 8'h00;
        dma_request_pin_n = 2'h0;
        src_valid = 1'b0;
        src_data = 32'h0;
        dst_ready = 1'b1;
        repeat (6) @(negedge clock);
        resetn = 1'b1;
        idle(3);
        check(bus_request, 0);
        check(src_ready, 1);
        check(unit_start_ff, 0);
        run_case(2, SRC_AUTO, CAT_MEM, SZ_32, 0, 0);
        run_case(1, SRC_AUTO, CAT_MEM, SZ_128, 1, 0);
        run_case(3, SRC_TIMER, CAT_MEM, SZ_8, 0, 0);
        run_case(0, SRC_EXT, CAT_MEM, SZ_16, 1, 0);
        run_case(2, SRC_SERIAL, CAT_PERI, SZ_32, 1, 0);
        run_case(3, SRC_ADC, CAT_PERI, SZ_16, 1, 0);
        run_case(3, SRC_FIFO_SERIAL, CAT_PERI, SZ_8, 0, 0);
        run_case(2, SRC_ADC, CAT_MEM, SZ_8, 0, 1);
        run_case(0, SRC_EXT, CAT_ACK, SZ_128, 0, 0);
        run_case(2, SRC_EXT, CAT_MEM, SZ_32, 0, 1);
        run_case(1, SRC_AUTO, CAT_PERI, SZ_128, 0, 1);
        run_case(2, SRC_EXT, CAT_ACK, SZ_32, 0, 1);
        run_case(1, SRC_AUTO, CAT_ACK, SZ_32, 0, 1);
        prio(1'b0);
        prio(1'b1);
        // pin released mid-burst: the accepted unit ends, bus goes back
        @(negedge clock);
        cfg(0, SRC_EXT, CAT_MEM, SZ_32, 1'b1);
        seen.delete();
        ch_enable[0] = 1'b1;
        while (seen.size() < 2) @(negedge clock);
        dma_request_pin_n[0] = 1'b1;
        units = seen.size();
        idle(30);
        check(seen.size() - units <= 1, 1);
        check(bus_request, 0);
        ch_enable = 4'h0;
        // buffer: stalled receiver first fills it, then random traffic
        for (int i = 0; i < 60; i++) begin
            @(negedge clock);
            src_valid = 1'($random(seed));
            src_data = $random(seed);
            dst_ready = (i > 8) && 1'($random(seed));
            #1;
            check(src_ready, q.size() < BUF_DEPTH);
            check(dst_valid, q.size() > 0);
            if (dst_valid === 1'b1 && dst_ready) begin
                check(dst_data, q.pop_front());
            end
            if (src_valid && src_ready === 1'b1) begin
                q.push_back(src_data);
            end
        end
        while (q.size() > 0) begin
            @(negedge clock);
            src_valid = 1'b0;
            dst_ready = 1'b1;
            #1;
            check(dst_data, q.pop_front());
        end
        idle(2);
        check(dst_valid, 0);
        end_sim();
    end
endmodule // dma_bus_mode_channel_arbiter_bench

`default_nettype wire
